// ---- adcirq_pkg.sv ----
// adcirq_pkg: constants and types shared by the adc interrupt flag logic.
// assumes the link and top modules import the whole package in their module headers.
package adcirq_pkg;

   // ---------------------------------------------------------------
   // flag layout, shared by the status byte and the interrupt register
   // ---------------------------------------------------------------
   localparam int FLAG_W = 3;
   localparam int FLAG_POR = 0;
   localparam int FLAG_CRC = 1;
   localparam int FLAG_DR = 2;
   localparam logic [FLAG_W-1:0] FLAGS_NONE = 3'h0;
   localparam logic [FLAG_W-1:0] FLAGS_POR_ONLY = 3'h1;
   localparam logic [FLAG_W-1:0] FLAGS_IDLE_N = 3'h7;

   // ---------------------------------------------------------------
   // link events, one toggle each
   // ---------------------------------------------------------------
   localparam int EVT_W = 3;
   localparam int EVT_STATUS_DONE = 0;
   localparam int EVT_IRQREG_DONE = 1;
   localparam int EVT_DATA_READ = 2;

   // ---------------------------------------------------------------
   // keys and timing counts, in modulator clock periods
   // ---------------------------------------------------------------
   localparam logic [7:0] UNLOCK_KEY = 8'hA5;
   localparam int STARTUP_CYC = 256;
   localparam int DR_PRE_CLEAR_CYC = 16;
   localparam int STP_CNT_W = 9;
   localparam int STP_WIDTH_DEF_CYC = 4;
   localparam int CONV_LEN_W_DEF = 16;

   // start pulse sequence
   typedef enum {ST_IDLE, ST_STARTUP, ST_PULSE} adcirq_stp_state_t;

endpackage : adcirq_pkg

// ---- adcirq_link_if.sv ----
// adcirq_link_if: carries pending flags and event toggles between domains.
// assumes pend_* are flops on the modulator clock and evt_toggle flops on sck.
`timescale 1ns/1ps
interface adcirq_link_if;
   import adcirq_pkg::*;
   logic [FLAG_W-1:0] pend_status;
   logic [FLAG_W-1:0] pend_irqreg;
   logic [EVT_W-1:0] evt_toggle;
   modport core (output pend_status, output pend_irqreg, input evt_toggle);
   modport link (input pend_status, input pend_irqreg, output evt_toggle);
endinterface : adcirq_link_if

// ---- adcirq_sync2.sv ----
// adcirq_sync2: two flip-flop synchroniser, any width, settable reset value.
// assumes each bit is a level or a toggle; multi-bit words must be quasi-static.
`timescale 1ns/1ps
module adcirq_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= RST_VAL;
         q_out <= RST_VAL;
      end else if (ce_in) begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule : adcirq_sync2

// ---- adcirq_link.sv ----
// adcirq_link: sck-domain side; latches flags for spi and reports spi events.
// assumes the spi decoder gives one-cycle pulses on sck, already edge aligned.
`timescale 1ns/1ps
module adcirq_link import adcirq_pkg::*; (
   input wire logic sck_in,
   input wire logic rst_n_in,
   input wire logic addr_detect_in,
   input wire logic irqreg_start_in,
   input wire logic status_done_in,
   input wire logic irqreg_done_in,
   input wire logic data_read_in,
   output logic [FLAG_W-1:0] status_flags_n_out,
   output logic [FLAG_W-1:0] irqreg_flags_n_out,
   adcirq_link_if.link lnk
);
   logic [2*FLAG_W-1:0] pend_s;
   logic [EVT_W-1:0] evt_tog_reg;

   // pending flags change rarely, so a plain two-flop copy is enough; sck stands still
   // between frames, so a latch pulse needs at least two sck rises of its frame before it
   adcirq_sync2 #(.W(2*FLAG_W), .RST_VAL({FLAGS_NONE, FLAGS_NONE})) u_pend_sync (
      .clk_in(sck_in),
      .rst_n_in(rst_n_in),
      .ce_in(1'b1),
      .d_in({lnk.pend_irqreg, lnk.pend_status}),
      .q_out(pend_s)
   );

   // all three status bits are caught together at address detection
   always_ff @(posedge sck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_flags_n_out <= FLAGS_IDLE_N;
      end else if (addr_detect_in) begin
         status_flags_n_out <= ~pend_s[FLAG_W-1:0]; // [RULE24]
      end
   end

   // interrupt register image is caught as its read begins
   always_ff @(posedge sck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irqreg_flags_n_out <= FLAGS_IDLE_N;
      end else if (irqreg_start_in) begin
         irqreg_flags_n_out <= ~pend_s[2*FLAG_W-1:FLAG_W]; // [RULE25]
      end
   end

   // events leave as toggles, since sck may stop right after them
   always_ff @(posedge sck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         evt_tog_reg <= '0;
      end else begin
         evt_tog_reg <= evt_tog_reg ^ {data_read_in, irqreg_done_in, status_done_in};
      end
   end

   assign lnk.evt_toggle = evt_tog_reg;
endmodule : adcirq_link

// ---- adcirq_top.sv ----
// adcirq_top: interrupt flag logic of a delta-sigma adc, pin and flag paths.
// assumes CLOCK_IN is the modulator clock and the sequencer, crc engine and
// spi decoder sit outside and talk to this block through pulses and levels.
`timescale 1ns/1ps

// Functional notes
// RULE1 - conversion-ready event fires on the modulator clock when a result lands
// RULE2 - status byte shows ready low once after the event, then high
// RULE3 - ready bit in interrupt register goes low until a full read
// RULE4 - conversion-ready drives the interrupt pin low at once
// RULE5 - pin ready assertion ends on result read or 16 cycles early
// RULE6 - conversion start appears only on the pin, never in flags
// RULE7 - start pulse enable gates the start pin output, default on
// RULE8 - start pulse marks sampling after a 256-cycle start-up delay
// RULE9 - in scan mode only the first conversion gets a start pulse
// RULE10 - start pulse releases the pin by itself after a fixed width
// RULE11 - status byte shows power-on low first, again after a new power-up
// RULE12 - power-on bit in interrupt register low at power-up until read
// RULE13 - pin held low while either supply monitor reports low supply
// RULE14 - power-on pin clears only on chip-select fall with both supplies good
// RULE15 - host may poll chip select and watch the pin for power-up
// RULE16 - power-on has top priority, over the modulator bitstream too
// RULE17 - status byte shows crc error low once after each mismatch
// RULE18 - crc bit in interrupt register low after mismatch until read
// RULE19 - crc error holds pin low until unlock key write clears it
// RULE20 - start fast command clears crc interrupt and restarts checksum
// RULE21 - crc error beats every pin source except power-on
// RULE22 - host clears a spurious crc error after locking with a restart
// RULE23 - upper source bit high lets only power-on and crc drive the pin; the code also lets a selected modulator bitstream drive it
// RULE24 - status byte flags are caught together on address detection
// RULE25 - interrupt register flags are caught as its read starts
// RULE26 - pin low while any permitted source is active, else high
module adcirq_top import adcirq_pkg::*; #(
   parameter int STP_WIDTH_CYC = STP_WIDTH_DEF_CYC,
   parameter int CONV_LEN_W = CONV_LEN_W_DEF
) (
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic SPI_SCK_IN,
   input wire logic SPI_CS_N_IN,
   input wire logic SPI_ADDR_DETECT_IN,
   input wire logic SPI_IRQREG_START_IN,
   input wire logic SPI_STATUS_DONE_IN,
   input wire logic SPI_IRQREG_DONE_IN,
   input wire logic SPI_DATA_READ_IN,
   input wire logic AVDD_LOW_IN,
   input wire logic DVDD_LOW_IN,
   input wire logic CONV_DONE_IN,
   input wire logic CONT_OR_SCAN_IN,
   input wire logic [CONV_LEN_W-1:0] CONV_LEN_IN,
   input wire logic FAST_START_IN,
   input wire logic CRC_MISMATCH_IN,
   input wire logic LOCK_WRITE_IN,
   input wire logic [7:0] LOCK_VALUE_IN,
   input wire logic START_PULSE_ENABLE_IN,
   input wire logic IRQ_MODE_HI_IN,
   input wire logic MODULATOR_BITSTREAM_SEL_IN,
   input wire logic MODULATOR_BITSTREAM_IN,
   output logic IRQ_N_OUT,
   output logic [FLAG_W-1:0] STATUS_FLAGS_N_OUT,
   output logic [FLAG_W-1:0] IRQREG_FLAGS_N_OUT,
   output logic CRC_RESTART_OUT,
   output logic CRC_STOP_OUT
);

   // ---------------------------------------------------------------
   // local constants
   // ---------------------------------------------------------------
   localparam logic [CONV_LEN_W-1:0] DR_PRE = CONV_LEN_W'(DR_PRE_CLEAR_CYC);
   localparam logic [STP_CNT_W-1:0] STARTUP_LAST = STP_CNT_W'(STARTUP_CYC - 1);
   localparam logic [STP_CNT_W-1:0] STP_LAST = STP_CNT_W'(STP_WIDTH_CYC - 1);

   // pending flags: hardware set always wins over a same-cycle clear
   function automatic logic [FLAG_W-1:0] flag_update(
      input logic [FLAG_W-1:0] cur,
      input logic [FLAG_W-1:0] set,
      input logic clr
   );
      return (cur & ~{FLAG_W{clr}}) | set;
   endfunction : flag_update

   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic rst_n;
   logic cs_n_s;
   logic avdd_low_s;
   logic dvdd_low_s;
   logic [EVT_W-1:0] evt_tog_s;
   logic cs_n_d_reg;
   logic [EVT_W-1:0] evt_tog_d_reg;
   adcirq_link_if lnk ();

   // reset runs free of the clock enable so release is never stuck
   adcirq_sync2 #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
      .clk_in(CLOCK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(1'b1),
      .d_in(1'b1),
      .q_out(rst_n)
   );

   // supplies assumed low while in reset, so the pin starts asserted
   adcirq_sync2 #(.W(3 + EVT_W), .RST_VAL({3'h7, {EVT_W{1'b0}}})) u_pin_sync (
      .clk_in(CLOCK_IN),
      .rst_n_in(rst_n),
      .ce_in(CE_IN),
      .d_in({SPI_CS_N_IN, AVDD_LOW_IN, DVDD_LOW_IN, lnk.evt_toggle}),
      .q_out({cs_n_s, avdd_low_s, dvdd_low_s, evt_tog_s})
   );

   // sck-side logic; reset is the released core reset
   adcirq_link u_link (
      .sck_in(SPI_SCK_IN),
      .rst_n_in(rst_n),
      .addr_detect_in(SPI_ADDR_DETECT_IN),
      .irqreg_start_in(SPI_IRQREG_START_IN),
      .status_done_in(SPI_STATUS_DONE_IN),
      .irqreg_done_in(SPI_IRQREG_DONE_IN),
      .data_read_in(SPI_DATA_READ_IN),
      .status_flags_n_out(STATUS_FLAGS_N_OUT),
      .irqreg_flags_n_out(IRQREG_FLAGS_N_OUT),
      .lnk(lnk)
   );

   // delayed copies for edge detection, taken after the second stage
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         cs_n_d_reg <= 1'b1;
         evt_tog_d_reg <= '0;
      end else if (CE_IN) begin
         cs_n_d_reg <= cs_n_s;
         evt_tog_d_reg <= evt_tog_s;
      end
   end

   logic [EVT_W-1:0] evt_p;
   logic cs_fall;
   logic supply_ok;
   logic unlock;

   // decoded one-cycle events
   assign evt_p = evt_tog_s ^ evt_tog_d_reg;
   assign cs_fall = cs_n_d_reg & ~cs_n_s;
   assign supply_ok = ~avdd_low_s & ~dvdd_low_s;
   assign unlock = LOCK_WRITE_IN && (LOCK_VALUE_IN == UNLOCK_KEY);

   // ---------------------------------------------------------------
   // pending flags for the status byte and interrupt register
   // ---------------------------------------------------------------
   logic [FLAG_W-1:0] pend_status_reg;
   logic [FLAG_W-1:0] pend_irqreg_reg;
   logic [FLAG_W-1:0] flag_set;

   // start pulse never enters these sets, only the pin [RULE6]
   always_comb begin
      flag_set = FLAGS_NONE;
      flag_set[FLAG_DR] = CONV_DONE_IN; // [RULE1]
      flag_set[FLAG_CRC] = CRC_MISMATCH_IN;
      flag_set[FLAG_POR] = ~supply_ok; // supply drop counts as a new power-on
   end

   // status byte flags, cleared when a status byte has gone out
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pend_status_reg <= FLAGS_POR_ONLY; // [RULE11]
      end else if (CE_IN) begin
         pend_status_reg <= flag_update(pend_status_reg, flag_set,
                                        evt_p[EVT_STATUS_DONE]); // [RULE2] [RULE17]
      end
   end

   // interrupt register flags, cleared after a complete register read
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pend_irqreg_reg <= FLAGS_POR_ONLY; // [RULE12]
      end else if (CE_IN) begin
         pend_irqreg_reg <= flag_update(pend_irqreg_reg, flag_set,
                                        evt_p[EVT_IRQREG_DONE]); // [RULE3] [RULE18]
      end
   end

   assign lnk.pend_status = pend_status_reg;
   assign lnk.pend_irqreg = pend_irqreg_reg;

   // ---------------------------------------------------------------
   // conversion start pulse
   // ---------------------------------------------------------------
   adcirq_stp_state_t stp_state_reg;
   logic [STP_CNT_W-1:0] stp_cnt_reg;

   // one pulse per start command: in scan mode only the first conversion
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         stp_state_reg <= ST_IDLE;
         stp_cnt_reg <= '0;
      end else if (CE_IN) begin
         if (FAST_START_IN) begin
            stp_state_reg <= ST_STARTUP; // a restart begins the delay again
            stp_cnt_reg <= '0;
         end else begin
            case (stp_state_reg)
               ST_IDLE: begin
                  stp_cnt_reg <= '0;
               end
               ST_STARTUP: begin
                  if (stp_cnt_reg == STARTUP_LAST) begin
                     stp_state_reg <= ST_PULSE; // [RULE8] [RULE9]
                     stp_cnt_reg <= '0;
                  end else begin
                     stp_cnt_reg <= stp_cnt_reg + 1'b1;
                  end
               end
               ST_PULSE: begin
                  if (stp_cnt_reg == STP_LAST) begin
                     stp_state_reg <= ST_IDLE; // [RULE10]
                     stp_cnt_reg <= '0;
                  end else begin
                     stp_cnt_reg <= stp_cnt_reg + 1'b1;
                  end
               end
               default: begin
                  stp_state_reg <= ST_IDLE;
                  stp_cnt_reg <= '0;
               end
            endcase
         end
      end
   end

   logic sampling_start;
   assign sampling_start = (stp_state_reg == ST_STARTUP) && (stp_cnt_reg == STARTUP_LAST);

   // ---------------------------------------------------------------
   // data ready pin source
   // ---------------------------------------------------------------
   logic [CONV_LEN_W-1:0] conv_cnt_reg;
   logic dr_pin_reg;
   logic pre_clear;

   // cycles since the last result or sampling start; saturates at the top
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         conv_cnt_reg <= '0;
      end else if (CE_IN) begin
         if (CONV_DONE_IN || sampling_start) begin
            conv_cnt_reg <= '0;
         end else if (conv_cnt_reg != '1) begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
         end
      end
   end

   // early release avoids a pin stuck low when results are never read
   assign pre_clear = CONT_OR_SCAN_IN && (CONV_LEN_IN > DR_PRE)
                      && (conv_cnt_reg == CONV_LEN_IN - DR_PRE); // [RULE5]

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         dr_pin_reg <= 1'b0;
      end else if (CE_IN) begin
         if (CONV_DONE_IN) begin
            dr_pin_reg <= 1'b1; // [RULE4]
         end else if (evt_p[EVT_DATA_READ] || pre_clear) begin
            dr_pin_reg <= 1'b0; // [RULE5]
         end
      end
   end

   // ---------------------------------------------------------------
   // power-on and crc pin sources
   // ---------------------------------------------------------------
   logic por_pin_reg;
   logic crc_pin_reg;

   // host polls by pulsing chip select until this lets go [RULE15]
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         por_pin_reg <= 1'b1;
      end else if (CE_IN) begin
         if (!supply_ok) begin
            por_pin_reg <= 1'b1; // [RULE13]
         end else if (cs_fall) begin
            por_pin_reg <= 1'b0; // [RULE14]
         end
      end
   end

   // a mismatch in the same cycle as a clear keeps the pin asserted
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         crc_pin_reg <= 1'b0;
      end else if (CE_IN) begin
         if (CRC_MISMATCH_IN) begin
            crc_pin_reg <= 1'b1;
         end else if (unlock || FAST_START_IN) begin
            crc_pin_reg <= 1'b0; // [RULE19] [RULE20] [RULE22]
         end
      end
   end

   // checksum engine controls: stop on unlock, restart on start command
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         CRC_RESTART_OUT <= 1'b0;
         CRC_STOP_OUT <= 1'b0;
      end else if (CE_IN) begin
         CRC_RESTART_OUT <= FAST_START_IN; // [RULE20]
         CRC_STOP_OUT <= unlock; // [RULE19]
      end
   end

   // ---------------------------------------------------------------
   // interrupt pin
   // ---------------------------------------------------------------
   logic stp_pin;
   logic irq_n_next;
   assign stp_pin = (stp_state_reg == ST_PULSE) && START_PULSE_ENABLE_IN; // [RULE7]

   // priority: power-on, crc, bitstream, then the permitted event sources
   always_comb begin
      if (por_pin_reg) begin
         irq_n_next = 1'b0; // [RULE16]
      end else if (crc_pin_reg) begin
         irq_n_next = 1'b0; // [RULE21]
      end else if (MODULATOR_BITSTREAM_SEL_IN) begin
         irq_n_next = MODULATOR_BITSTREAM_IN;
      end else begin
         irq_n_next = ~(~IRQ_MODE_HI_IN & (dr_pin_reg | stp_pin)); // [RULE23] [RULE26]
      end
   end

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         IRQ_N_OUT <= 1'b0; // power-on asserts the pin from the start
      end else if (CE_IN) begin
         IRQ_N_OUT <= irq_n_next;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!rst_n);

   sequence s_dr_event;
      CE_IN && CONV_DONE_IN ##1 CE_IN && !MODULATOR_BITSTREAM_SEL_IN && !IRQ_MODE_HI_IN;
   endsequence
   sequence s_startup_done;
      CE_IN && !FAST_START_IN && stp_state_reg == ST_STARTUP && stp_cnt_reg == STARTUP_LAST;
   endsequence

   property p_dr_pin_fall;
      s_dr_event |=> !IRQ_N_OUT;
   endproperty
   a_dr_pin_fall: assert property (p_dr_pin_fall) else $error("ready did not pull pin"); // [RULE4]

   property p_dr_read_clear;
      CE_IN && evt_p[EVT_DATA_READ] && !CONV_DONE_IN |=> !dr_pin_reg;
   endproperty
   a_dr_read_clear: assert property (p_dr_read_clear) else $error("read left ready"); // [RULE5]

   property p_dr_pre_clear;
      CE_IN && pre_clear && !CONV_DONE_IN |=> !dr_pin_reg;
   endproperty
   a_dr_pre_clear: assert property (p_dr_pre_clear) else $error("early release lost"); // [RULE5]

   property p_status_set_wins;
      CE_IN && CONV_DONE_IN && evt_p[EVT_STATUS_DONE] |=> pend_status_reg[FLAG_DR];
   endproperty
   a_status_set_wins: assert property (p_status_set_wins) else $error("ready lost"); // [RULE2]

   property p_irqreg_clear;
      CE_IN && evt_p[EVT_IRQREG_DONE] && !CRC_MISMATCH_IN |=> !pend_irqreg_reg[FLAG_CRC];
   endproperty
   a_irqreg_clear: assert property (p_irqreg_clear) else $error("crc bit not cleared"); // [RULE18]

   property p_stp_pulse;
      s_startup_done ##1 CE_IN && !FAST_START_IN && START_PULSE_ENABLE_IN
         && !por_pin_reg && !crc_pin_reg && !MODULATOR_BITSTREAM_SEL_IN && !IRQ_MODE_HI_IN
         |=> !IRQ_N_OUT;
   endproperty
   a_stp_pulse: assert property (p_stp_pulse) else $error("start pulse missing"); // [RULE8]

   property p_stp_end;
      CE_IN && !FAST_START_IN && stp_state_reg == ST_PULSE && stp_cnt_reg == STP_LAST
         |=> stp_state_reg == ST_IDLE;
   endproperty
   a_stp_end: assert property (p_stp_end) else $error("start pulse did not end"); // [RULE10]

   property p_por_hold;
      CE_IN && !supply_ok |=> por_pin_reg ##1 (!CE_IN || !IRQ_N_OUT);
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("supply low but pin free"); // [RULE13]

   property p_por_release;
      CE_IN && cs_fall && supply_ok |=> !por_pin_reg;
   endproperty
   a_por_release: assert property (p_por_release) else $error("power-on not released"); // [RULE14]

   property p_crc_override;
      CE_IN && crc_pin_reg |=> !IRQ_N_OUT;
   endproperty
   a_crc_override: assert property (p_crc_override) else $error("crc did not win"); // [RULE21]

   property p_crc_unlock;
      CE_IN && unlock && !CRC_MISMATCH_IN |=> !crc_pin_reg && CRC_STOP_OUT;
   endproperty
   a_crc_unlock: assert property (p_crc_unlock) else $error("unlock did not clear"); // [RULE19]

   property p_mode_hi;
      CE_IN && IRQ_MODE_HI_IN && !por_pin_reg && !crc_pin_reg && !MODULATOR_BITSTREAM_SEL_IN
         |=> IRQ_N_OUT;
   endproperty
   a_mode_hi: assert property (p_mode_hi) else $error("masked source drove pin"); // [RULE23]

endmodule : adcirq_top

// ---- adcirq_host_model.sv ----
// adcirq_host_model: host end of the spi link; sck runs only inside frames.
// assumes the decoder pulses are sampled on the rising sck edge.
`timescale 1ns/1ps
module adcirq_host_model (
   output logic sck_out,
   output logic cs_n_out,
   output logic [4:0] pulse_out
);
   // ---------------------------------
   // frames
   // ---------------------------------
   // idle: no frame, sck stands low
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      pulse_out = 5'h00;
   end
   // one 64 ns sck period; the pulse changes after the falling edge
   task automatic step(input logic [4:0] p);
      pulse_out = p;
      #32 sck_out = 1'b1;
      #32 sck_out = 1'b0;
   endtask : step
   // every frame opens with a cs fall, which also polls for power-up
   task automatic frame(input logic [4:0] first, input logic [4:0] last);
      cs_n_out = 1'b0;
      #100;
      // address bits come first: the flag copy on sck needs two rises to catch up
      step(5'h00);
      step(5'h00);
      step(first);
      step(5'h00);
      step(last);
      step(5'h00);
      #50 cs_n_out = 1'b1;
      #200;
   endtask : frame
endmodule : adcirq_host_model

// ---- adc_interrupt_flag_logic_tb.sv ----
// adc_interrupt_flag_logic_tb: drives the flag logic and its spi host model.
// assumes default parameters of the top module.
`timescale 1ns/1ps
module adc_interrupt_flag_logic_tb;
   import adcirq_pkg::*;
   logic clk, rst_n, avdd_low, dvdd_low, cont, spe, mode_hi, bs_sel, bs, sck, cs_n, irq_n;
   logic restart, stop;
   logic [1:0] seen;
   logic [3:0] ev; // conv done, crc mismatch, fast start, lock write
   logic [7:0] lockv;
   logic [4:0] hp;
   logic [2:0] st, ir, n;
   int miscompares, check_count;
   wire logic [2:0] irq3 = {2'h0, irq_n};
   adcirq_top dut (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .SPI_SCK_IN(sck), .SPI_CS_N_IN(cs_n),
      .SPI_ADDR_DETECT_IN(hp[0]), .SPI_IRQREG_START_IN(hp[1]), .SPI_STATUS_DONE_IN(hp[2]),
      .SPI_IRQREG_DONE_IN(hp[3]), .SPI_DATA_READ_IN(hp[4]), .AVDD_LOW_IN(avdd_low),
      .DVDD_LOW_IN(dvdd_low), .CONV_DONE_IN(ev[0]), .CONT_OR_SCAN_IN(cont),
      .CONV_LEN_IN(16'h0028), .FAST_START_IN(ev[2]), .CRC_MISMATCH_IN(ev[1]),
      .LOCK_WRITE_IN(ev[3]), .LOCK_VALUE_IN(lockv), .START_PULSE_ENABLE_IN(spe),
      .IRQ_MODE_HI_IN(mode_hi), .MODULATOR_BITSTREAM_SEL_IN(bs_sel),
      .MODULATOR_BITSTREAM_IN(bs), .IRQ_N_OUT(irq_n), .STATUS_FLAGS_N_OUT(st),
      .IRQREG_FLAGS_N_OUT(ir), .CRC_RESTART_OUT(restart), .CRC_STOP_OUT(stop));
   adcirq_host_model host (.sck_out(sck), .cs_n_out(cs_n), .pulse_out(hp));
   // crc pulses last one cycle, so remember them
   always @(posedge clk) seen <= seen | {restart === 1'b1, stop === 1'b1};
   // clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string what, input logic [2:0] got, input logic [2:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic pulse(input int k);
      @(posedge clk) ev <= 4'h1 << k;
      @(posedge clk) ev <= 4'h0;
   endtask : pulse
   // saturating count, so a stuck pin cannot wrap back to the expected width
   task automatic low_cycles(output logic [2:0] c);
      c = 3'h0;
      repeat (300) begin
         tick(1);
         if (irq_n === 1'b0 && c != 3'h7) c = c + 3'h1;
      end
   endtask : low_cycles
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   // hang guard
   initial begin
      #300000;
      miscompares++;
      give_verdict();
   end
   // ---------------------------------
   // scenarios
   // ---------------------------------
   initial begin
      {rst_n, cont, mode_hi, bs_sel, bs, ev, seen, lockv} = '0;
      {avdd_low, dvdd_low, spe} = 3'h7;
      miscompares = 0;
      check_count = 0;
      tick(12);
      @(posedge clk) rst_n <= 1'b1;
      @(posedge clk) dvdd_low <= 1'b0;
      tick(6);
      chk("irq", irq3, 3'h0);
      host.frame(5'h01, 5'h04);
      tick(8);
      chk("irq", irq3, 3'h0);
      chk("st", st, 3'h6);
      @(posedge clk) avdd_low <= 1'b0;
      tick(6);
      host.frame(5'h01, 5'h04);
      tick(8);
      chk("irq", irq3, 3'h1);
      host.frame(5'h01, 5'h04);
      chk("st", st, 3'h7);
      host.frame(5'h02, 5'h08);
      chk("ir", ir, 3'h6);
      host.frame(5'h02, 5'h08);
      chk("ir", ir, 3'h7);
      pulse(0);
      tick(3);
      chk("irq", irq3, 3'h0);
      host.frame(5'h01, 5'h04);
      chk("st", st, 3'h3);
      host.frame(5'h10, 5'h00);
      tick(8);
      chk("irq", irq3, 3'h1);
      @(posedge clk) cont <= 1'b1;
      pulse(0);
      tick(12);
      chk("irq", irq3, 3'h0);
      tick(20);
      chk("irq", irq3, 3'h1);
      @(posedge clk) {cont, mode_hi} <= 2'b01;
      pulse(0);
      tick(6);
      chk("irq", irq3, 3'h1);
      @(posedge clk) mode_hi <= 1'b0;
      tick(4);
      chk("irq", irq3, 3'h0);
      host.frame(5'h01, 5'h04);
      chk("st", st, 3'h3);
      host.frame(5'h02, 5'h08);
      chk("ir", ir, 3'h3);
      host.frame(5'h10, 5'h00);
      @(posedge clk) {bs_sel, bs} <= 2'b11;
      pulse(1);
      tick(3);
      chk("irq", irq3, 3'h0);
      pulse(3);
      tick(4);
      chk("irq", irq3, 3'h0);
      host.frame(5'h01, 5'h04);
      chk("st", st, 3'h5);
      host.frame(5'h02, 5'h08);
      chk("ir", ir, 3'h5);
      @(posedge clk) lockv <= UNLOCK_KEY;
      pulse(3);
      tick(4);
      chk("irq", irq3, 3'h1);
      @(posedge clk) bs_sel <= 1'b0;
      pulse(1);
      tick(3);
      pulse(2);
      tick(4);
      chk("irq", irq3, 3'h1);
      chk("crc", {1'b0, seen}, 3'h3);
      tick(246);
      chk("irq", irq3, 3'h1);
      low_cycles(n);
      chk("n", n, 3'(STP_WIDTH_DEF_CYC));
      host.frame(5'h01, 5'h04);
      chk("st", st, 3'h5);
      @(posedge clk) spe <= 1'b0;
      pulse(2);
      low_cycles(n);
      chk("n", n, 3'h0);
      give_verdict();
   end
endmodule : adc_interrupt_flag_logic_tb
